// ---- apw_board_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module apw_board_model (
  // Pins from the sequencer.
  input wire logic power_ctl_o,
  input wire logic power_ctl_oe,
  input wire logic host_reset_o,
  input wire logic host_reset_oe,
  // Host power state chosen by the bench.
  input wire logic host_on,
  // Resolved wire levels.
  output logic power_line,
  output logic reset_line,
  output logic power_sense
);
  // The board pulls its switch inputs up, so a released line reads high, never the last level.
  assign power_line = power_ctl_oe ? power_ctl_o : 1'b1;
  assign reset_line = host_reset_oe ? host_reset_o : 1'b1;
  // Sense pin kept in its pull-up drive mode, pulled down only while the host is off.
  assign power_sense = host_on;
endmodule
`default_nettype wire

// ---- apw_pkg.sv ----
`default_nettype none
package apw_pkg;

  // Clock and time base.
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_HZ = 32;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int TICKS_PER_SEC = TICK_HZ;

  // Gesture and pulse times in milliseconds, as printed.
  localparam int HOLD_LONG_MS = 4000;
  localparam int PRESS_SHORT_MS = 250;
  localparam int RESET_PULSE_MS = 1000;
  localparam int EXTEND_MAX_MS = 5000;
  localparam int DEFAULT_PULSE_MS = 1000;

  // The same times in 1/32 second ticks.
  localparam logic [8:0] HOLD_LONG_TICKS = 9'(HOLD_LONG_MS * TICK_HZ / 1000);
  localparam logic [8:0] PRESS_SHORT_TICKS = 9'(PRESS_SHORT_MS * TICK_HZ / 1000);
  localparam logic [8:0] RESET_PULSE_TICKS = 9'(RESET_PULSE_MS * TICK_HZ / 1000);
  localparam logic [8:0] EXTEND_MAX_TICKS = 9'(EXTEND_MAX_MS * TICK_HZ / 1000);
  localparam logic [7:0] DEFAULT_PULSE_LEN = 8'(DEFAULT_PULSE_MS * TICK_HZ / 1000);

  // Cycles that the self restart holds off host commands.
  localparam int RESTART_CYCLES = 16;

  // Function mask bits.
  localparam int MB_RESET_INVERT = 1;
  localparam int MB_POWER_INVERT = 2;
  localparam int MB_BLANK = 4;
  localparam int MB_KEY_RESET = 5;
  localparam int MB_KEY_PWR_ON = 6;
  localparam int MB_KEY_PWR_OFF = 7;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // Command packet types.
  localparam logic [7:0] CMD_POWER_SWITCH = 8'h1C;
  localparam logic [7:0] CMD_WATCHDOG = 8'h1D;
  localparam logic [7:0] CMD_READ_STATUS = 8'h1E;
  localparam logic [7:0] ACK_FLAG = 8'h40;
  localparam logic [7:0] STATUS_LEN = 8'h0F;
  localparam int STATUS_MASK_BYTE = 7;
  localparam int STATUS_WD_BYTE = 8;

  // Register byte offsets.
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_ACK = 5'h04;
  localparam logic [4:0] REG_STAT = 5'h08;
  localparam logic [4:0] REG_RESP0 = 5'h0C;
  localparam logic [4:0] REG_RESP3 = 5'h18;

  // Field positions.
  localparam int ACK_VALID_BIT = 16;
  localparam int ACK_BAD_BIT = 17;

  // Sequencer states.
  typedef enum logic [2:0] {
    APW_IDLE, APW_RST_PULSE, APW_PWR_PULSE, APW_PWR_EXTEND, APW_RESTART
  } apw_state_t;

  // Message the display shows.
  typedef enum logic [1:0] {
    APW_MSG_NONE, APW_MSG_RESET, APW_MSG_POWER_ON, APW_MSG_POWER_OFF
  } apw_msg_t;

endpackage
`default_nettype wire

// ---- apw_power_seq.sv ----
`timescale 1ns/100ps
`default_nettype none
module apw_power_seq #(
  parameter int TICK_CYCLES = apw_pkg::TICK_CYCLES,
  parameter int RESTART_CYCLES = apw_pkg::RESTART_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM register slave.
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Host power sense and keypad pins.
  input wire logic power_sense_pin,
  input wire logic confirm_key_pin,
  input wire logic cancel_key_pin,
  // Power-control and reset pins toward the motherboard.
  output logic power_ctl_o,
  output logic power_ctl_oe,
  output logic host_reset_o,
  output logic host_reset_oe,
  // Display side.
  output logic blank_display_when_host_down,
  output logic [1:0] message,
  output logic self_restart
);

  localparam logic [7:0] RESTART_LAST = 8'(RESTART_CYCLES - 1);

  typedef struct packed {
    apw_pkg::apw_state_t state;
    apw_pkg::apw_msg_t msg;
    logic drive_rst;
    logic drive_pwr;
    logic restart;
    logic self_after;
    logic [8:0] pulse_cnt;
    logic [8:0] conf_cnt;
    logic [8:0] canc_cnt;
    logic [4:0] sec_cnt;
    logic [7:0] mask;
    logic [7:0] pulse_len;
    logic wd_en;
    logic [7:0] wd_cnt;
    logic sense_d;
    logic [7:0] lock_cnt;
    logic ack_valid;
    logic ack_bad;
    logic [7:0] ack_type;
    logic [7:0] ack_len;
    logic [7:0] resp_mask;
    logic [7:0] resp_wd;
    logic bus_done;
    logic [31:0] rdata;
  } apw_st_t;

  apw_st_t s_r;
  apw_st_t s_nxt;

  logic [2:0] pins_sync;
  logic sense;
  logic confirm;
  logic cancel;
  logic tick;
  logic tick_clr;

  // Pins come from outside the clock domain.
  apw_sync #(
    .W(3)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({cancel_key_pin, confirm_key_pin, power_sense_pin}),
    .sync_out(pins_sync)
  );

  assign sense = pins_sync[0];
  assign confirm = pins_sync[1];
  assign cancel = pins_sync[2];

  // The tick restarts with each pulse so pulse lengths are exact tick multiples.
  apw_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .reset_n(reset_n),
    .clr(tick_clr),
    .tick(tick)
  );

  // Status response byte k; only the bytes this block owns are non-zero.
  function automatic logic [7:0] resp_byte(input int k, input logic [7:0] m,
                                           input logic [7:0] w);
    logic [7:0] b;
    b = 8'h00;
    if (k == apw_pkg::STATUS_MASK_BYTE) begin
      b = m;
    end else if (k == apw_pkg::STATUS_WD_BYTE) begin
      b = w;
    end
    return b;
  endfunction

  // All sequencing, watchdog, command and bus logic.
  always_comb begin
    logic req;
    logic wr_acc;
    logic cmd_stb;
    logic sec_pulse;
    logic wd_fire;
    logic conf_long;
    logic conf_short;
    logic canc_long;
    logic pulse_end;
    logic [7:0] ctype;
    logic [7:0] clen;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [2:0] widx;
    sec_pulse = 1'b0;
    wd_fire = 1'b0;
    conf_long = 1'b0;
    conf_short = 1'b0;
    canc_long = 1'b0;
    pulse_end = 1'b0;
    req = avs_read || avs_write;
    wr_acc = avs_write && s_r.bus_done;
    cmd_stb = wr_acc && avs_address == apw_pkg::REG_CMD && avs_byteenable[0];
    ctype = avs_writedata[7:0];
    clen = avs_writedata[15:8];
    d0 = avs_writedata[23:16];
    d1 = avs_writedata[31:24];
    widx = '0;
    s_nxt = s_r;
    s_nxt.restart = 1'b0;
    s_nxt.sense_d = sense;
    tick_clr = 1'b0;

    // Key hold timers count whole ticks and reset the moment a key lifts.
    if (!confirm) begin
      s_nxt.conf_cnt = '0;
    end else if (tick && s_r.conf_cnt != apw_pkg::HOLD_LONG_TICKS) begin
      s_nxt.conf_cnt = s_r.conf_cnt + 9'd1;
    end
    if (!cancel) begin
      s_nxt.canc_cnt = '0;
    end else if (tick && s_r.canc_cnt != apw_pkg::HOLD_LONG_TICKS) begin
      s_nxt.canc_cnt = s_r.canc_cnt + 9'd1;
    end
    // Each gesture fires once, on the tick that completes its hold.
    conf_long = tick && confirm && s_r.conf_cnt == apw_pkg::HOLD_LONG_TICKS - 9'd1;
    conf_short = tick && confirm && s_r.conf_cnt == apw_pkg::PRESS_SHORT_TICKS - 9'd1;
    canc_long = tick && cancel && s_r.canc_cnt == apw_pkg::HOLD_LONG_TICKS - 9'd1;

    // Seconds prescaler for the watchdog.
    sec_pulse = tick && s_r.sec_cnt == 5'(apw_pkg::TICKS_PER_SEC - 1);
    if (tick) begin
      s_nxt.sec_cnt = sec_pulse ? 5'd0 : s_r.sec_cnt + 5'd1;
    end

    // Watchdog countdown; it disarms itself when it fires.
    if (sec_pulse && s_r.wd_en) begin
      if (s_r.wd_cnt == 8'd1) begin
        s_nxt.wd_cnt = 8'd0;
        s_nxt.wd_en = 1'b0;
        wd_fire = 1'b1;
      end else begin
        s_nxt.wd_cnt = s_r.wd_cnt - 8'd1;
      end
    end

    // Pulse length counter, cleared at entry to each pulse state below.
    if (tick) begin
      s_nxt.pulse_cnt = s_r.pulse_cnt + 9'd1;
    end

    // Sequencer.
    unique case (s_r.state)
      apw_pkg::APW_IDLE: begin
        s_nxt.pulse_cnt = '0;
        if (wd_fire) begin
          s_nxt.state = apw_pkg::APW_RST_PULSE;
          s_nxt.drive_rst = 1'b1;
          s_nxt.self_after = 1'b0;
          tick_clr = 1'b1;
        end else if (s_r.mask[apw_pkg::MB_KEY_RESET] && sense && conf_long) begin
          s_nxt.state = apw_pkg::APW_RST_PULSE;
          s_nxt.drive_rst = 1'b1;
          s_nxt.self_after = 1'b1;
          s_nxt.msg = apw_pkg::APW_MSG_RESET;
          tick_clr = 1'b1;
        end else if (s_r.mask[apw_pkg::MB_KEY_PWR_ON] && !sense && conf_short) begin
          s_nxt.state = apw_pkg::APW_PWR_PULSE;
          s_nxt.drive_pwr = 1'b1;
          s_nxt.self_after = 1'b1;
          s_nxt.msg = apw_pkg::APW_MSG_POWER_ON;
          tick_clr = 1'b1;
        end else if (s_r.mask[apw_pkg::MB_KEY_PWR_OFF] && sense && canc_long) begin
          s_nxt.state = apw_pkg::APW_PWR_PULSE;
          s_nxt.drive_pwr = 1'b1;
          s_nxt.self_after = 1'b0;
          s_nxt.msg = apw_pkg::APW_MSG_POWER_OFF;
          tick_clr = 1'b1;
        end else if (s_r.mask[apw_pkg::MB_BLANK] && sense && !s_r.sense_d) begin
          s_nxt.state = apw_pkg::APW_RESTART;
          s_nxt.restart = 1'b1;
          s_nxt.lock_cnt = '0;
        end
      end
      apw_pkg::APW_RST_PULSE: begin
        if (tick && s_r.pulse_cnt == apw_pkg::RESET_PULSE_TICKS - 9'd1) begin
          pulse_end = 1'b1;
          s_nxt.drive_rst = 1'b0;
        end
      end
      apw_pkg::APW_PWR_PULSE: begin
        if (tick && s_r.pulse_cnt == {1'b0, s_r.pulse_len} - 9'd1) begin
          s_nxt.pulse_cnt = '0;
          if (!s_r.self_after && cancel) begin
            s_nxt.state = apw_pkg::APW_PWR_EXTEND;
          end else begin
            pulse_end = 1'b1;
            s_nxt.drive_pwr = 1'b0;
          end
        end
      end
      apw_pkg::APW_PWR_EXTEND: begin
        if (!cancel || (tick && s_r.pulse_cnt == apw_pkg::EXTEND_MAX_TICKS - 9'd1)) begin
          pulse_end = 1'b1;
          s_nxt.drive_pwr = 1'b0;
        end
      end
      apw_pkg::APW_RESTART: begin
        // Boot state: watchdog off, pulse counter and message cleared; the gesture timers keep counting.
        s_nxt.lock_cnt = s_r.lock_cnt + 8'd1;
        if (s_r.lock_cnt == RESTART_LAST) begin
          s_nxt.state = apw_pkg::APW_IDLE;
          s_nxt.msg = apw_pkg::APW_MSG_NONE;
          s_nxt.wd_en = 1'b0;
          s_nxt.wd_cnt = 8'd0;
          s_nxt.pulse_cnt = '0;
        end
      end
    endcase

    // A finished pulse either restarts the module or returns to rest.
    if (pulse_end) begin
      if (s_r.self_after) begin
        s_nxt.state = apw_pkg::APW_RESTART;
        s_nxt.restart = 1'b1;
        s_nxt.lock_cnt = '0;
      end else begin
        s_nxt.state = apw_pkg::APW_IDLE;
        s_nxt.msg = apw_pkg::APW_MSG_NONE;
      end
    end

    // Acknowledge clear by software; a new acknowledge below wins over it.
    if (wr_acc && avs_address == apw_pkg::REG_ACK && avs_byteenable[2]) begin
      if (avs_writedata[apw_pkg::ACK_VALID_BIT]) begin
        s_nxt.ack_valid = 1'b0;
      end
      if (avs_writedata[apw_pkg::ACK_BAD_BIT]) begin
        s_nxt.ack_bad = 1'b0;
      end
    end

    // Host command packets; dropped silently while restarting.
    if (cmd_stb && s_r.state != apw_pkg::APW_RESTART) begin
      if (ctype == apw_pkg::CMD_POWER_SWITCH && (clen == 8'd1 || clen == 8'd2)) begin
        s_nxt.mask = d0;
        s_nxt.pulse_len = (clen == 8'd2 && d1 != 8'h00) ? d1 : apw_pkg::DEFAULT_PULSE_LEN;
        s_nxt.ack_valid = 1'b1;
        s_nxt.ack_type = ctype | apw_pkg::ACK_FLAG;
        s_nxt.ack_len = 8'h00;
      end else if (ctype == apw_pkg::CMD_WATCHDOG && clen == 8'd1) begin
        s_nxt.wd_cnt = d0;
        s_nxt.wd_en = (d0 != 8'h00);
        s_nxt.sec_cnt = '0;
        s_nxt.ack_valid = 1'b1;
        s_nxt.ack_type = ctype | apw_pkg::ACK_FLAG;
        s_nxt.ack_len = 8'h00;
      end else if (ctype == apw_pkg::CMD_READ_STATUS && clen == 8'd0) begin
        s_nxt.resp_mask = s_r.mask;
        s_nxt.resp_wd = s_r.wd_cnt;
        s_nxt.ack_valid = 1'b1;
        s_nxt.ack_type = ctype | apw_pkg::ACK_FLAG;
        s_nxt.ack_len = apw_pkg::STATUS_LEN;
      end else begin
        s_nxt.ack_bad = 1'b1;
      end
    end

    // Bus: one wait cycle, read data captured then presented at release.
    s_nxt.bus_done = req && !s_r.bus_done;
    if (avs_read && !s_r.bus_done) begin
      s_nxt.rdata = 32'h0000_0000;
      if (avs_address == apw_pkg::REG_ACK) begin
        s_nxt.rdata = {14'h0000, s_r.ack_bad, s_r.ack_valid, s_r.ack_len, s_r.ack_type};
      end else if (avs_address == apw_pkg::REG_STAT) begin
        s_nxt.rdata = {s_r.msg, blank_display_when_host_down, s_r.drive_rst,
                       s_r.drive_pwr, s_r.state == apw_pkg::APW_RESTART, sense,
                       s_r.wd_en, s_r.pulse_len, s_r.wd_cnt, s_r.mask};
      end else if (avs_address >= apw_pkg::REG_RESP0 && avs_address <= apw_pkg::REG_RESP3) begin
        widx = 3'(avs_address[4:2] - apw_pkg::REG_RESP0[4:2]);
        s_nxt.rdata = {resp_byte(4 * widx + 3, s_r.resp_mask, s_r.resp_wd),
                       resp_byte(4 * widx + 2, s_r.resp_mask, s_r.resp_wd),
                       resp_byte(4 * widx + 1, s_r.resp_mask, s_r.resp_wd),
                       resp_byte(4 * widx, s_r.resp_mask, s_r.resp_wd)};
      end
    end
  end

  // Reset brings the block up as at power-up: outputs floating, watchdog off.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.state <= apw_pkg::APW_IDLE;
      s_r.msg <= apw_pkg::APW_MSG_NONE;
      s_r.mask <= apw_pkg::MASK_RESET;
      s_r.pulse_len <= apw_pkg::DEFAULT_PULSE_LEN;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs float unless driven; drive level follows the inversion bits.
  assign host_reset_oe = s_r.drive_rst;
  assign host_reset_o = s_r.mask[apw_pkg::MB_RESET_INVERT];
  assign power_ctl_oe = s_r.drive_pwr;
  assign power_ctl_o = s_r.mask[apw_pkg::MB_POWER_INVERT];

  // Blanking follows the synchronised sense while the blank mask bit is set; the keypad stays live meanwhile.
  assign blank_display_when_host_down = s_r.mask[apw_pkg::MB_BLANK] && !sense;
  assign message = s_r.msg;
  assign self_restart = s_r.restart;

  // Bus answer.
  assign avs_waitrequest = (avs_read || avs_write) && !s_r.bus_done;
  assign avs_readdata = s_r.rdata;

endmodule
`default_nettype wire

// ---- apw_power_seq_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module apw_power_seq_props #(
  parameter int TICK_CYCLES = apw_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Bus handshake.
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Pins and display side.
  input wire logic power_sense_pin,
  input wire logic power_ctl_o,
  input wire logic power_ctl_oe,
  input wire logic host_reset_o,
  input wire logic host_reset_oe,
  input wire logic blank_display_when_host_down,
  input wire logic self_restart
);
  localparam int RST_CYCLES = 32 * TICK_CYCLES;
  localparam int PWR_MAX = (255 + 160) * TICK_CYCLES;
  int rst_len_r;
  int pwr_len_r;

  // Count how long each output has been driven, so the reset width is checked exactly and the power width against a bound.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rst_len_r <= 0;
      pwr_len_r <= 0;
    end else begin
      rst_len_r <= host_reset_oe ? rst_len_r + 1 : 0;
      pwr_len_r <= power_ctl_oe ? pwr_len_r + 1 : 0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // A request waits one cycle and is then answered.
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  wait_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high without a request");
  rst_len_a: assert property ($fell(host_reset_oe) |-> rst_len_r == RST_CYCLES)
    else $error("reset pulse width wrong");
  pwr_max_a: assert property (power_ctl_oe |-> pwr_len_r < PWR_MAX)
    else $error("power pin driven too long");
  pwr_hold_a: assert property (power_ctl_oe && $past(power_ctl_oe) |-> $stable(power_ctl_o))
    else $error("power level changed within a pulse");
  rst_hold_a: assert property (host_reset_oe && $past(host_reset_oe) |-> $stable(host_reset_o))
    else $error("reset level changed within a pulse");
  restart_one_a: assert property (self_restart |=> !self_restart)
    else $error("restart pulse longer than one cycle");
  restart_quiet_a: assert property (self_restart |-> !power_ctl_oe && !host_reset_oe)
    else $error("pin still driven at restart");
  blank_sense_a: assert property (blank_display_when_host_down |-> !$past(power_sense_pin, 2))
    else $error("display blanked while host is on");
endmodule

bind apw_power_seq apw_power_seq_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .clk, .reset_n, .avs_read, .avs_write, .avs_waitrequest, .power_sense_pin,
  .power_ctl_o, .power_ctl_oe, .host_reset_o, .host_reset_oe,
  .blank_display_when_host_down, .self_restart
);
`default_nettype wire

// ---- apw_power_seq_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module apw_power_seq_tb;
  localparam int TC = 8;
  localparam int RC = 16;
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [3:0] avs_byteenable;
  logic confirm_key_pin, cancel_key_pin, host_on, power_sense, power_line, reset_line;
  logic power_ctl_o, power_ctl_oe, host_reset_o, host_reset_oe;
  logic blank_display_when_host_down, self_restart, lvl, seen;
  logic [1:0] message, msg;
  int failures, compares, len;

  // Short tick so every gesture and pulse fits a short run.
  apw_power_seq #(.TICK_CYCLES(TC), .RESTART_CYCLES(RC)) u_dut (
    .clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .power_sense_pin(power_sense), .confirm_key_pin,
    .cancel_key_pin, .power_ctl_o, .power_ctl_oe, .host_reset_o, .host_reset_oe,
    .blank_display_when_host_down, .message, .self_restart
  );
  apw_board_model u_board (
    .power_ctl_o, .power_ctl_oe, .host_reset_o, .host_reset_oe, .host_on,
    .power_line, .reset_line, .power_sense
  );

  // Free running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("Comparisons: %0d, mismatches: %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [31:0] cmd(input logic [7:0] t, input logic [7:0] n,
                                      input logic [7:0] b0, input logic [7:0] b1);
    return {b1, b0, n, t};
  endfunction

  // One Avalon access; the request is held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    logic ok;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    ok = (avs_waitrequest === 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
    if (!ok) begin
      chk("bus_answer", 32'h1, 32'h0);
      give_verdict();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] w);
    logic [31:0] unused;
    bus(1'b1, a, w, unused);
  endtask

  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0, d);
  endtask

  // Send a command, expect a clean acknowledge, then clear it for the next one.
  task automatic send_ok(input logic [31:0] w, input logic [7:0] elen);
    wr(apw_pkg::REG_CMD, w);
    rd(apw_pkg::REG_ACK);
    chk("ack", {15'h0000, 1'b1, elen, w[7:0] | apw_pkg::ACK_FLAG}, d);
    wr(apw_pkg::REG_ACK, 32'h0003_0000);
  endtask

  // Wait a bounded time for a pulse on one pin, then measure it; len stays 0 if none.
  task automatic pulse(input bit rst, input int bound);
    int n;
    n = 0;
    len = 0;
    while ((rst ? host_reset_oe : power_ctl_oe) !== 1'b1 && n < bound) begin
      @(posedge clk);
      n++;
    end
    lvl = rst ? host_reset_o : power_ctl_o;
    msg = message;
    // The board's resolved line must carry the driven level while the pin is asserted.
    if ((rst ? host_reset_oe : power_ctl_oe) === 1'b1) begin
      chk("line_level", {31'h0, lvl}, {31'h0, rst ? reset_line : power_line});
    end
    while ((rst ? host_reset_oe : power_ctl_oe) === 1'b1 && len < 4000) begin
      @(posedge clk);
      len++;
    end
  endtask

  task automatic wait_restart(input int bound);
    int n;
    n = 0;
    seen = (self_restart === 1'b1);
    while (n < bound && !seen) begin
      @(posedge clk);
      seen = (self_restart === 1'b1);
      n++;
    end
  endtask

  // Main sequence; each step leaves the block idle for the next, except the key reset, the power-on press and the closing sense step, which leave it restarting.
  initial begin
    failures = 0;
    compares = 0;
    reset_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    confirm_key_pin = 1'b0;
    cancel_key_pin = 1'b0;
    host_on = 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk("oe_idle", 32'h0, {30'h0, power_ctl_oe, host_reset_oe});
    chk("line_idle", 32'h3, {30'h0, reset_line, power_line});
    rd(apw_pkg::REG_STAT);
    chk("stat_reset", 32'h0020_0000, d);
    rd(5'h1C);
    chk("unmapped", 32'h0, d);
    wr(apw_pkg::REG_CMD, cmd(apw_pkg::CMD_POWER_SWITCH, 8'h03, 8'hE6, 8'h04));
    rd(apw_pkg::REG_ACK);
    chk("bad_len", 32'h2, {30'h0, d[17:16]});
    wr(apw_pkg::REG_ACK, 32'h0003_0000);
    send_ok(cmd(apw_pkg::CMD_POWER_SWITCH, 8'h02, 8'hE6, 8'h04), 8'h00);
    host_on <= 1'b1;
    repeat (4) @(posedge clk);
    cancel_key_pin <= 1'b1;
    pulse(1'b0, 140 * TC);
    chk("off_len", 164 * TC, len);
    chk("off_level", 32'h1, {31'h0, lvl});
    chk("off_msg", {30'h0, apw_pkg::APW_MSG_POWER_OFF}, {30'h0, msg});
    cancel_key_pin <= 1'b0;
    repeat (4) @(posedge clk);
    confirm_key_pin <= 1'b1;
    pulse(1'b1, 140 * TC);
    chk("rst_len", 32 * TC, len);
    chk("rst_level", 32'h1, {31'h0, lvl});
    chk("rst_msg", {30'h0, apw_pkg::APW_MSG_RESET}, {30'h0, msg});
    wr(apw_pkg::REG_CMD, cmd(apw_pkg::CMD_WATCHDOG, 8'h01, 8'h05, 8'h00));
    confirm_key_pin <= 1'b0;
    repeat (2 * RC) @(posedge clk);
    rd(apw_pkg::REG_ACK);
    chk("cmd_ignored", 32'h0, {30'h0, d[17:16]});
    send_ok(cmd(apw_pkg::CMD_POWER_SWITCH, 8'h01, 8'h40, 8'h00), 8'h00);
    rd(apw_pkg::REG_STAT);
    chk("pulse_default", 32'h20, {24'h0, d[23:16]});
    cancel_key_pin <= 1'b1;
    pulse(1'b0, 140 * TC);
    chk("off_disabled", 32'h0, len);
    cancel_key_pin <= 1'b0;
    host_on <= 1'b0;
    repeat (4) @(posedge clk);
    confirm_key_pin <= 1'b1;
    pulse(1'b0, 4 * TC);
    chk("short_press", 32'h0, len);
    confirm_key_pin <= 1'b0;
    repeat (4 * TC) @(posedge clk);
    confirm_key_pin <= 1'b1;
    pulse(1'b0, 20 * TC);
    chk("on_len", 32 * TC, len);
    chk("on_level", 32'h0, {31'h0, lvl});
    chk("on_msg", {30'h0, apw_pkg::APW_MSG_POWER_ON}, {30'h0, msg});
    wait_restart(RC);
    chk("on_restart", 32'h1, {31'h0, seen});
    confirm_key_pin <= 1'b0;
    host_on <= 1'b1;
    repeat (2 * RC) @(posedge clk);
    send_ok(cmd(apw_pkg::CMD_POWER_SWITCH, 8'h01, 8'h12, 8'h00), 8'h00);
    send_ok(cmd(apw_pkg::CMD_WATCHDOG, 8'h01, 8'h01, 8'h00), 8'h00);
    send_ok(cmd(apw_pkg::CMD_READ_STATUS, 8'h00, 8'h00, 8'h00), apw_pkg::STATUS_LEN);
    rd(apw_pkg::REG_RESP0 + 5'h04);
    chk("resp_mask", 32'h12, {24'h0, d[31:24]});
    rd(apw_pkg::REG_RESP0 + 5'h08);
    chk("resp_wd", 32'h01, {24'h0, d[7:0]});
    pulse(1'b1, 40 * TC);
    chk("wd_len", 32 * TC, len);
    chk("wd_level", 32'h1, {31'h0, lvl});
    pulse(1'b1, 80 * TC);
    chk("wd_once", 32'h0, len);
    send_ok(cmd(apw_pkg::CMD_WATCHDOG, 8'h01, 8'h02, 8'h00), 8'h00);
    send_ok(cmd(apw_pkg::CMD_WATCHDOG, 8'h01, 8'h00, 8'h00), 8'h00);
    pulse(1'b1, 100 * TC);
    chk("wd_off", 32'h0, len);
    send_ok(cmd(apw_pkg::CMD_READ_STATUS, 8'h00, 8'h00, 8'h00), apw_pkg::STATUS_LEN);
    host_on <= 1'b0;
    repeat (4) @(posedge clk);
    chk("blank", 32'h1, {31'h0, blank_display_when_host_down});
    host_on <= 1'b1;
    wait_restart(10);
    chk("sense_restart", 32'h1, {31'h0, seen});
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- apw_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module apw_sync #(
  parameter int W = 3
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Asynchronous inputs and their synchronised copies.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
  } apw_sync_st_t;

  apw_sync_st_t s_r;
  apw_sync_st_t s_nxt;

  // The first stage feeds only the second, so metastability stays contained.
  always_comb begin
    s_nxt.ff1 = async_in;
    s_nxt.ff2 = s_r.ff1;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_out = s_r.ff2;

endmodule
`default_nettype wire

// ---- apw_tick.sv ----
`timescale 1ns/100ps
`default_nettype none
module apw_tick #(
  parameter int CYCLES = apw_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Restart the period so a pulse starts on a whole tick.
  input wire logic clr,
  // One-cycle pulse every tick period.
  output logic tick
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] TOP = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
  } apw_tick_st_t;

  apw_tick_st_t s_r;
  apw_tick_st_t s_nxt;

  // Free-running divider; a clear restarts the period from zero.
  always_comb begin
    s_nxt = s_r;
    if (clr || s_r.cnt == TOP) begin
      s_nxt.cnt = '0;
    end else begin
      s_nxt.cnt = s_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = (s_r.cnt == TOP);

endmodule
`default_nettype wire
